// File: design/ip_boot_consts.svh
`ifndef IP_BOOT_CONSTS_SVH
`define IP_BOOT_CONSTS_SVH

// ************************************************************
// Register word offsets
// ************************************************************
`define OFS_OWN_ADDR      4'h0
`define OFS_SUBNET_MASK   4'h1
`define OFS_GATEWAY       4'h2
`define OFS_CONTROL       4'h3
`define OFS_STATUS        4'h4
`define OFS_NAME_NUMBER   4'h5
`define OFS_NV_ADDR       4'h6
`define OFS_NV_MASK       4'h7
`define OFS_NV_GATEWAY    4'h8

// ************************************************************
// Reset and fixed values
// ************************************************************
`define NV_ADDR_DEFAULT   32'hC0A8640A
`define NET_PREFIX        24'hC0A864
`define DERIVED_MASK      32'hFFFFFF00
`define NV_MASK_DEFAULT   32'hFFFFFF00
`define NV_GW_DEFAULT     32'h00000000
`define HOST_MAX          8'h9F
`define HOST_MIN          8'h01
`define HOST_ZERO_SUB     8'h01
`define HOST_BCAST_SUB    8'hFE
`define MAC_ZERO          8'h00
`define MAC_BCAST         8'hFF
`define LOW_LAST_NAME     4'h9
`define LOW_SERVER_A      4'hA
`define LOW_SERVER_B      4'hB
`define LOW_STORED_C      4'hC
`define LOW_STORED_D      4'hD
`define LOW_CLEAR         4'hE
`define LOW_DERIVED       4'hF
`define ASCII_ZERO        8'h30
`define DIGIT_TEN         4'hA
`define DIGIT_BASE        8'h0A
`define HUNDRED           8'h64
`define BOOT_SAMPLE_CNT   2'h2
`define BOOT_LAST_CNT     2'h3
`define CTRL_SAVE_BIT     0
`define CTRL_CLEAR_BIT    1
`define CTRL_DUP_BIT      2
`define CTRL_CONN_BIT     3

`endif

// File: design/ip_boot_pkg.sv
package ip_boot_pkg;

    typedef enum logic [2:0] {
        MODE_NAME    = 3'b000,
        MODE_SERVER  = 3'b001,
        MODE_STORED  = 3'b010,
        MODE_CLEAR   = 3'b011,
        MODE_DERIVED = 3'b100
    } boot_mode_t;

    typedef enum logic [2:0] {
        LED_OFF        = 3'b000,
        LED_NO_PARAMS  = 3'b001,
        LED_READY      = 3'b010,
        LED_DUP_ADDR   = 3'b011,
        LED_WAIT_NET   = 3'b100
    } led_code_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] mask;
        logic [31:0] gateway;
    } net_cfg_t;

endpackage

// File: design/ip_address_boot_config.sv
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ip_boot_consts.svh"

module ip_address_boot_config
    import ip_boot_pkg::*;
#(
    parameter int CONN_POLL_CYCLES = 250
) (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic [3:0]  low_digit_switch,
    input  wire logic [3:0]  high_digit_switch,
    input  wire logic [7:0]  mac_last_byte,
    input  wire logic        server_addr_valid,
    input  wire logic [31:0] server_addr,
    input  wire logic [31:0] server_mask,
    input  wire logic [31:0] server_gateway,
    input  wire logic        dup_addr_detect,
    input  wire logic        link_up,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             server_request,
    output logic             server_by_name,
    output logic [23:0]      server_lookup_digits,
    output net_cfg_t         active_cfg,
    output boot_mode_t       boot_mode,
    output led_code_t        led_code,
    output logic             green_led,
    output logic             net_config_enable
);

    // ************************************************************
    // Switch synchronisers and boot sample
    // ************************************************************
    logic [3:0] low_s1_r;
    logic [3:0] low_s2_r;
    logic [3:0] high_s1_r;
    logic [3:0] high_s2_r;
    logic       dup_s1_r;
    logic       dup_s2_r;
    logic       link_s1_r;
    logic       link_s2_r;
    logic [1:0] boot_cnt_r;
    logic       sampled_r;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            low_s1_r  <= 4'h0;
            low_s2_r  <= 4'h0;
            high_s1_r <= 4'h0;
            high_s2_r <= 4'h0;
            dup_s1_r  <= 1'b0;
            dup_s2_r  <= 1'b0;
            link_s1_r <= 1'b0;
            link_s2_r <= 1'b0;
        end else begin
            low_s1_r  <= low_digit_switch;
            low_s2_r  <= low_s1_r;
            high_s1_r <= high_digit_switch;
            high_s2_r <= high_s1_r;
            dup_s1_r  <= dup_addr_detect;
            dup_s2_r  <= dup_s1_r;
            link_s1_r <= link_up;
            link_s2_r <= link_s1_r;
        end
    end

    // Wait for synchroniser fill so the sample never sees reset zeros
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            boot_cnt_r <= 2'h0;
        end else if (boot_cnt_r != `BOOT_LAST_CNT) begin
            boot_cnt_r <= boot_cnt_r + 2'h1;
        end
    end

    wire sample_now = (boot_cnt_r == `BOOT_SAMPLE_CNT) && !sampled_r;

    // ************************************************************
    // Mode decode, latched once per boot
    // ************************************************************
    boot_mode_t mode_nxt;

    always_comb begin
        unique case (low_s2_r)
            `LOW_SERVER_A, `LOW_SERVER_B: mode_nxt = MODE_SERVER;
            `LOW_STORED_C, `LOW_STORED_D: mode_nxt = MODE_STORED;
            `LOW_CLEAR:                   mode_nxt = MODE_CLEAR;
            `LOW_DERIVED:                 mode_nxt = MODE_DERIVED;
            default:                      mode_nxt = MODE_NAME;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sampled_r <= 1'b0;
            boot_mode <= MODE_NAME;
        end else if (sample_now) begin
            sampled_r <= 1'b1;
            boot_mode <= mode_nxt;
        end
    end

    // ************************************************************
    // Switch number and name digits
    // ************************************************************
    logic [7:0] switch_num;
    logic [7:0] hundreds;
    logic [7:0] rem_tens;

    always_comb begin
        switch_num = 8'({4'h0, high_s2_r} * `DIGIT_TEN) + {4'h0, low_s2_r};
        hundreds   = (switch_num >= `HUNDRED) ? 8'h01 : 8'h00;
        rem_tens   = switch_num - 8'(hundreds * `HUNDRED);
    end

    wire host_ok = (switch_num >= `HOST_MIN) && (switch_num <= `HOST_MAX);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            server_lookup_digits <= 24'h0;
        end else if (sample_now) begin
            server_lookup_digits <= {`ASCII_ZERO + hundreds,
                                     `ASCII_ZERO + 8'(rem_tens / `DIGIT_BASE),
                                     `ASCII_ZERO + 8'(rem_tens % `DIGIT_BASE)};
        end
    end

    // ************************************************************
    // Non-volatile copy, staged writes and control
    // ************************************************************
    net_cfg_t   nv_r;
    net_cfg_t   stage_r;
    logic       nv_valid_r;
    logic       cleared_r;
    logic [7:0] clear_host_r;
    logic       conn_en_r;

    wire bus_ok  = net_config_enable;
    // Writes land only at the accept edge, so a stalled request is never applied twice
    wire wr_hit  = avs_write && !avs_waitrequest && bus_ok;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Stored copy follows nrst here; a true power cycle keeps it in the outside store
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            nv_r       <= '{`NV_ADDR_DEFAULT, `NV_MASK_DEFAULT, `NV_GW_DEFAULT};
            nv_valid_r <= 1'b1;
        end else if (sample_now && mode_nxt == MODE_CLEAR) begin
            nv_valid_r <= 1'b0;
        end else if (boot_mode == MODE_CLEAR && sampled_r && host_ok && !cleared_r) begin
            nv_r.addr  <= {nv_r.addr[31:8], switch_num};
            nv_valid_r <= 1'b1;
        end else if (wr_hit && avs_address == `OFS_CONTROL && avs_writedata[`CTRL_SAVE_BIT]) begin
            nv_r       <= stage_r;
            nv_valid_r <= 1'b1;
        end
    end

    // Switch number committed to the stored copy until ready is shown
    // Ready needs the same valid number on two edges, so a turning knob shows two-flash
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cleared_r    <= 1'b0;
            clear_host_r <= 8'h0;
        end else if (boot_mode == MODE_CLEAR && sampled_r) begin
            clear_host_r <= switch_num;
            cleared_r    <= host_ok && (clear_host_r == switch_num);
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stage_r   <= '{`NV_ADDR_DEFAULT, `NV_MASK_DEFAULT, `NV_GW_DEFAULT};
            conn_en_r <= 1'b1;
        end else if (wr_hit) begin
            unique case (avs_address)
                `OFS_NV_ADDR:    stage_r.addr    <= merge(stage_r.addr, avs_writedata, avs_byteenable);
                `OFS_NV_MASK:    stage_r.mask    <= merge(stage_r.mask, avs_writedata, avs_byteenable);
                `OFS_NV_GATEWAY: stage_r.gateway <= merge(stage_r.gateway, avs_writedata, avs_byteenable);
                `OFS_CONTROL:    conn_en_r       <= avs_byteenable[0] ? avs_writedata[`CTRL_CONN_BIT] : conn_en_r;
                default:         stage_r         <= stage_r;
            endcase
        end
    end

    // ************************************************************
    // Active configuration, taken once per boot
    // ************************************************************
    logic [7:0] derived_host;
    logic       cfg_valid_r;

    always_comb begin
        unique case (mac_last_byte)
            `MAC_ZERO:  derived_host = `HOST_ZERO_SUB;
            `MAC_BCAST: derived_host = `HOST_BCAST_SUB;
            default:    derived_host = mac_last_byte;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            active_cfg  <= '0;
            cfg_valid_r <= 1'b0;
        end else if (sample_now) begin
            unique case (mode_nxt)
                MODE_STORED: begin
                    active_cfg  <= nv_r;
                    cfg_valid_r <= nv_valid_r;
                end
                MODE_DERIVED: begin
                    active_cfg.addr    <= {`NET_PREFIX, derived_host};
                    active_cfg.mask    <= `DERIVED_MASK;
                    active_cfg.gateway <= {`NET_PREFIX, derived_host};
                    cfg_valid_r        <= 1'b1;
                end
                default: begin
                    active_cfg  <= '0;
                    cfg_valid_r <= 1'b0;
                end
            endcase
        end else if ((boot_mode == MODE_NAME || boot_mode == MODE_SERVER) && sampled_r
                     && server_addr_valid && !cfg_valid_r) begin
            active_cfg  <= '{server_addr, server_mask, server_gateway};
            cfg_valid_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            server_request <= 1'b0;
        end else begin
            server_request <= sampled_r && !cfg_valid_r
                              && (boot_mode == MODE_NAME || boot_mode == MODE_SERVER);
        end
    end

    // Latched with the mode so the identity kind never lags the decoded mode
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            server_by_name <= 1'b0;
        end else if (sample_now) begin
            server_by_name <= mode_nxt == MODE_NAME;
        end
    end

    // ************************************************************
    // Status LED code and periodic connection poll
    // ************************************************************
    logic [$clog2(CONN_POLL_CYCLES+1)-1:0] poll_cnt_r;
    logic dup_seen_r;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dup_seen_r <= 1'b0;
        end else if (cfg_valid_r && dup_s2_r) begin
            dup_seen_r <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            poll_cnt_r <= '0;
            green_led  <= 1'b0;
        end else if (poll_cnt_r == ($bits(poll_cnt_r))'(CONN_POLL_CYCLES - 1)) begin
            poll_cnt_r <= '0;
            green_led  <= conn_en_r && link_s2_r && cfg_valid_r;
        end else begin
            poll_cnt_r <= poll_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            led_code <= LED_OFF;
        end else if (!sampled_r) begin
            led_code <= LED_OFF;
        end else if (dup_seen_r) begin
            led_code <= LED_DUP_ADDR;
        end else if (boot_mode == MODE_CLEAR) begin
            led_code <= cleared_r ? LED_READY : LED_NO_PARAMS;
        end else if (cfg_valid_r) begin
            led_code <= LED_READY;
        end else if (boot_mode == MODE_STORED) begin
            led_code <= LED_NO_PARAMS;
        end else begin
            led_code <= LED_WAIT_NET;
        end
    end

    assign net_config_enable = cfg_valid_r && !dup_seen_r;

    // ************************************************************
    // Avalon-MM slave, one wait cycle then answer
    // ************************************************************
    logic ack_r;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !ack_r) begin
            if (!bus_ok) begin
                avs_readdata <= 32'h0;
            end else begin
                unique case (avs_address)
                    `OFS_OWN_ADDR:    avs_readdata <= active_cfg.addr;
                    `OFS_SUBNET_MASK: avs_readdata <= active_cfg.mask;
                    `OFS_GATEWAY:     avs_readdata <= active_cfg.gateway;
                    `OFS_CONTROL:     avs_readdata <= {28'h0, conn_en_r, 3'h0};
                    `OFS_STATUS:      avs_readdata <= {22'h0, green_led, nv_valid_r, cfg_valid_r,
                                                       led_code, 1'b0, boot_mode};
                    `OFS_NAME_NUMBER: avs_readdata <= {8'h0, server_lookup_digits};
                    `OFS_NV_ADDR:     avs_readdata <= stage_r.addr;
                    `OFS_NV_MASK:     avs_readdata <= stage_r.mask;
                    `OFS_NV_GATEWAY:  avs_readdata <= stage_r.gateway;
                    default:          avs_readdata <= 32'h0;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// File: test/ip_boot_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// *****
// Checker
// *****
module ip_boot_chk
    import ip_boot_pkg::*;
#(
    parameter int CONN_POLL_CYCLES = 250
) (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        server_request,
    input wire logic        server_by_name,
    input wire logic [23:0] server_lookup_digits,
    input wire net_cfg_t    active_cfg,
    input wire boot_mode_t  boot_mode,
    input wire led_code_t   led_code,
    input wire logic        dup_addr_detect,
    input wire logic        net_config_enable
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    logic bus_req;
    assign bus_req = avs_read || avs_write;

    a_bus_wait: assert property (bus_req && !$past(bus_req) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("wait state wrong");
    a_refuse_read: assert property (avs_read && !avs_waitrequest && !net_config_enable |=> avs_readdata == 32'h0)
        else $error("read not refused");
    a_derived_cfg: assert property (boot_mode == MODE_DERIVED |->
        active_cfg.mask == 32'hFFFFFF00 && active_cfg.gateway == active_cfg.addr)
        else $error("derived mask or gateway wrong");
    a_derived_host: assert property (boot_mode == MODE_DERIVED |->
        active_cfg.addr[31:8] == 24'hC0A864 && active_cfg.addr[7:0] inside {[8'h01:8'hFE]})
        else $error("derived address wrong");
    a_name_by: assert property (boot_mode == MODE_NAME && server_request |-> server_by_name)
        else $error("name mode not by name");
    a_server_by: assert property (boot_mode == MODE_SERVER |-> !server_by_name)
        else $error("server mode by name");
    a_digit_ascii: assert property (server_by_name |-> server_lookup_digits[23:16] inside {8'h30, 8'h31} &&
        server_lookup_digits[15:8] inside {[8'h30:8'h39]} && server_lookup_digits[7:0] inside {[8'h30:8'h39]})
        else $error("name digits not decimal");
    a_dup_flash: assert property ($rose(dup_addr_detect) |-> ##[1:8] led_code == LED_DUP_ADDR)
        else $error("duplicate code missing");

    cover property (boot_mode == MODE_DERIVED);
    cover property (boot_mode == MODE_CLEAR && led_code == LED_READY);
    cover property (avs_read && !avs_waitrequest && !net_config_enable);
endmodule

bind ip_address_boot_config ip_boot_chk #(.CONN_POLL_CYCLES(CONN_POLL_CYCLES)) u_chk (
    .mclk(mclk), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .server_request(server_request), .server_by_name(server_by_name),
    .server_lookup_digits(server_lookup_digits), .active_cfg(active_cfg),
    .boot_mode(boot_mode), .led_code(led_code), .dup_addr_detect(dup_addr_detect),
    .net_config_enable(net_config_enable)
);
`default_nettype wire

// File: test/ip_boot_partner.sv
`timescale 1ns/10ps
`default_nettype none
// *****
// Address server model
// *****
module ip_boot_partner (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        server_request,
    input  wire logic        server_by_name,
    input  wire logic        slow,
    input  wire logic [7:0]  mac_last_byte,
    output logic             server_addr_valid,
    output logic [31:0]      server_addr,
    output logic [31:0]      server_mask,
    output logic [31:0]      server_gateway
);
    logic [4:0]  wait_r;
    logic [31:0] ans;
    // Fixed address by name, else a distinct address per hardware byte
    assign ans = server_by_name ? 32'h0A000201 : {24'h0A0001, mac_last_byte};
    // Idle lines show the inverse so a stale value never passes
    assign server_addr = server_addr_valid ? ans : ~ans;
    assign server_mask = server_addr_valid ? 32'hFFFF0000 : 32'h0000FFFF;
    assign server_gateway = server_addr_valid ? 32'h0A000001 : 32'hF5FFFFFE;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wait_r <= 5'h0;
            server_addr_valid <= 1'b0;
        end else if (!server_request) begin
            wait_r <= 5'h0;
            server_addr_valid <= 1'b0;
        end else if (wait_r == (slow ? 5'h14 : 5'h01)) begin
            server_addr_valid <= 1'b1;
        end else begin
            wait_r <= wait_r + 5'h1;
        end
    end
endmodule
`default_nettype wire

// File: test/ip_address_boot_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
// *****
// Testbench
// *****
module ip_address_boot_config_tb
    import ip_boot_pkg::*;
;
    logic        mclk, nrst, dup, link, slow, rd, wr, sv, req, byn, gled, nce, wreq;
    logic [3:0]  lo, hi, adr, be;
    logic [7:0]  mac;
    logic [23:0] dig;
    logic [31:0] wd, rdat, sa, sm, sg, q;
    net_cfg_t    cfg;
    boot_mode_t  mode;
    led_code_t   led;
    int          errors, checks_done, cyc;

    ip_address_boot_config #(.CONN_POLL_CYCLES(4)) uut (
        .mclk(mclk), .nrst(nrst), .low_digit_switch(lo), .high_digit_switch(hi), .mac_last_byte(mac),
        .server_addr_valid(sv), .server_addr(sa), .server_mask(sm), .server_gateway(sg),
        .dup_addr_detect(dup), .link_up(link), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq),
        .server_request(req), .server_by_name(byn), .server_lookup_digits(dig), .active_cfg(cfg),
        .boot_mode(mode), .led_code(led), .green_led(gled), .net_config_enable(nce));
    ip_boot_partner srv (
        .mclk(mclk), .nrst(nrst), .server_request(req), .server_by_name(byn), .slow(slow),
        .mac_last_byte(mac), .server_addr_valid(sv), .server_addr(sa), .server_mask(sm),
        .server_gateway(sg));

    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            close_out();
        end
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic boot(input logic [3:0] l, input logic [3:0] h);
        @(posedge mclk);
        nrst <= 1'b0;
        lo <= l;
        hi <= h;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge mclk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        be <= b;
        do @(posedge mclk); while (wreq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic step(input logic [3:0] l, input logic [3:0] h, input led_code_t c);
        @(posedge mclk);
        lo <= l;
        hi <= h;
        for (int i = 0; i < 60 && led !== c; i++) @(posedge mclk);
    endtask

    task automatic t_derived;
        logic [7:0] m[4] = '{8'h06, 8'hA7, 8'h00, 8'hFF};
        logic [7:0] e[4] = '{8'h06, 8'hA7, 8'h01, 8'hFE};
        for (int i = 0; i < 4; i++) begin
            mac <= m[i];
            boot(4'hF, 4'h3);
            chk(cfg.addr, {24'hC0A864, e[i]}, "addr");
            chk(cfg.mask, 32'hFFFFFF00, "mask");
            chk(cfg.gateway, {24'hC0A864, e[i]}, "gateway");
            chk(mode, MODE_DERIVED, "mode");
        end
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        chk(q, 32'hC0A864FE, "read addr");
        bus(1'b0, 4'hF, 32'h0, 4'hF);
        chk(q, 32'h0, "unmapped");
        dup <= 1'b1;
        step(4'hF, 4'h3, LED_DUP_ADDR);
        chk(led, LED_DUP_ADDR, "dup led");
        link <= 1'b1;
        repeat (40) @(posedge mclk);
        chk(gled, 1'b1, "green on");
        link <= 1'b0;
        dup <= 1'b0;
        repeat (40) @(posedge mclk);
        chk(gled, 1'b0, "green off");
        $display("derived test done");
    endtask
    task automatic t_name;
        logic [3:0]  l[3] = '{4'h5, 4'h9, 4'h0};
        logic [3:0]  h[3] = '{4'h3, 4'hF, 4'h1};
        logic [23:0] d[3] = '{24'h303335, 24'h313539, 24'h303130};
        slow <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            boot(l[i], h[i]);
            chk(req, 1'b1, "request");
            chk(byn, 1'b1, "by name");
            chk(dig, d[i], "digits");
            chk(mode, MODE_NAME, "mode");
            repeat (30) @(posedge mclk);
            chk(cfg.addr, 32'h0A000201, "name addr");
        end
        slow <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            mac <= 8'h55 + i[7:0];
            boot(4'hA + i[3:0], 4'h7);
            chk(byn, 1'b0, "by name");
            chk(mode, MODE_SERVER, "mode");
            repeat (10) @(posedge mclk);
            chk(cfg.addr, {24'h0A0001, 8'h55 + i[7:0]}, "hw addr");
        end
        $display("server test done");
    endtask
    task automatic t_stored;
        boot(4'hD, 4'h5);
        chk(mode, MODE_STORED, "mode");
        boot(4'hC, 4'h2);
        chk(mode, MODE_STORED, "mode");
        chk(cfg.addr, 32'hC0A8640A, "addr");
        chk(cfg.mask, 32'hFFFFFF00, "mask");
        bus(1'b0, 4'h6, 32'h0, 4'hF);
        chk(q, 32'hC0A8640A, "nv addr");
        bus(1'b1, 4'h6, 32'h00000021, 4'h1);
        bus(1'b0, 4'h6, 32'h0, 4'hF);
        chk(q, 32'hC0A86421, "staged");
        bus(1'b1, 4'h3, 32'h00000009, 4'hF);
        chk(cfg.addr, 32'hC0A8640A, "active");
        bus(1'b1, 4'h9, 32'h00000001, 4'hF);
        bus(1'b0, 4'h9, 32'h0, 4'hF);
        chk(q, 32'h0, "unmapped");
        $display("stored test done");
    endtask
    task automatic t_clear;
        boot(4'hE, 4'hF);
        chk(mode, MODE_CLEAR, "mode");
        step(4'hE, 4'hF, LED_NO_PARAMS);
        chk(led, LED_NO_PARAMS, "led");
        chk(nce, 1'b0, "enable");
        bus(1'b0, 4'h0, 32'h0, 4'hF);
        chk(q, 32'h0, "refused");
        step(4'h2, 4'h1, LED_READY);
        chk(led, LED_READY, "led 12");
        step(4'hA, 4'hF, LED_NO_PARAMS);
        chk(led, LED_NO_PARAMS, "led 160");
        step(4'h9, 4'hF, LED_READY);
        chk(led, LED_READY, "led 159");
        step(4'h0, 4'h0, LED_NO_PARAMS);
        chk(led, LED_NO_PARAMS, "led 0");
        $display("clear test done");
    endtask

    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        {dup, link, slow, rd, wr} = 5'h0;
        lo = 4'hF;
        hi = 4'h0;
        adr = 4'h0;
        be = 4'hF;
        mac = 8'h00;
        wd = 32'h0;
        errors = 0;
        checks_done = 0;
        cyc = 0;
        t_derived();
        t_name();
        t_stored();
        t_clear();
        close_out();
    end
endmodule
`default_nettype wire
